//--- design/pci_regs_map.svh
// Register offsets, field positions and reset values of the PCI controller map.
// Assumes byte addresses relative to the module base, word aligned.
`ifndef PCI_REGS_MAP_SVH
`define PCI_REGS_MAP_SVH
`define CFG_BASE 16'h0b00
`define CFG_LAST 16'h0bfc
`define FIFO_BASE 16'h8400
`define FIFO_LAST 16'h84fc
`define OFF_IDENT 16'h0b00
`define OFF_STATCMD 16'h0b04
`define OFF_CLASSREV 16'h0b08
`define OFF_CFG1 16'h0b0c
`define OFF_BAR0 16'h0b10
`define OFF_BAR1 16'h0b14
`define OFF_CISPTR 16'h0b28
`define OFF_SUBSYS 16'h0b2c
`define OFF_ROMBASE 16'h0b30
`define OFF_CAPPTR 16'h0b34
`define OFF_CFG2 16'h0b3c
`define OFF_GSCR 16'h0b60
`define OFF_TBAT0 16'h0b64
`define OFF_TBAT1 16'h0b68
`define OFF_TCTL 16'h0b6c
`define OFF_IW0 16'h0b70
`define OFF_IW1 16'h0b74
`define OFF_IW2 16'h0b78
`define OFF_IWCFG 16'h0b80
`define OFF_ICTL 16'h0b84
`define OFF_ISTAT 16'h0b88
`define OFF_TX_SIZE 16'h8400
`define OFF_TX_START 16'h8404
`define OFF_TX_XFER 16'h8408
`define OFF_TX_ENABLE 16'h840c
`define OFF_TX_NEXT 16'h8410
`define OFF_TX_LASTWORD 16'h8414
`define OFF_TX_DONE 16'h8418
`define OFF_TX_STATUS 16'h841c
`define OFF_TX_FDATA 16'h8440
`define OFF_TX_FSTAT 16'h8444
`define OFF_TX_FCTL 16'h8448
`define OFF_TX_FALARM 16'h844c
`define OFF_TX_FRDPTR 16'h8450
`define OFF_TX_FWRPTR 16'h8454
`define OFF_RX_SIZE 16'h8480
`define OFF_RX_START 16'h8484
`define OFF_RX_XFER 16'h8488
`define OFF_RX_ENABLE 16'h848c
`define OFF_RX_NEXT 16'h8490
`define OFF_RX_DONE 16'h8498
`define OFF_RX_STATUS 16'h849c
`define OFF_RX_FDATA 16'h84c0
`define OFF_RX_FSTAT 16'h84c4
`define OFF_RX_FCTL 16'h84c8
`define OFF_RX_FALARM 16'h84cc
`define OFF_RX_FRDPTR 16'h84d0
`define OFF_RX_FWRPTR 16'h84d4
`define CFG_RSVD_LO 8'h10
`define CFG_RSVD_HI 8'h3f
`define GSCR_RESET_HOLD_POS 0
`define GSCR_RESET 32'h0000_0001
`define SC_STICKY_MASK 32'hf900_0000
`define SC_RW_MASK 32'h0000_035e
`define SC_FIXED 32'h02a0_0000
`define SC_PE_POS 31
`define SC_SE_POS 30
`define SC_MA_POS 29
`define SC_TR_POS 28
`define SC_TS_POS 27
`define SC_DP_POS 24
`define CLASSREV_VALUE 32'h0680_0000
`define CFG1_RW_MASK 32'h0000_f8ff
`define IDENT_DEVICE 16'h0001
`define IDENT_VENDOR 16'h0002
`endif

//--- design/pci_regs_pkg.sv
// Types shared by the PCI controller register bank.
// Assumes pci_regs_map.svh supplies all numeric constants.
package pci_regs_pkg;
   typedef enum {ST_IDLE, ST_ANSWER} bus_state_e;
   typedef struct packed {
      logic req;
      logic write;
      logic [15:0] addr;
      logic [31:0] wdata;
   } reg_req_s;
   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
   } reg_rsp_s;
   typedef struct packed {
      logic req;
      logic write;
      logic [5:0] dword;
      logic [31:0] wdata;
   } cfg_req_s;
   typedef struct packed {
      logic parityErr;
      logic sysErrSignalled;
      logic masterAbort;
      logic targetAbortRcvd;
      logic targetAbortSent;
      logic masterDataParity;
   } err_events_s;
endpackage : pci_regs_pkg

//--- design/sticky_status.sv
// Set-by-hardware, write-one-to-clear status bits.
// Assumes event pulses and clear masks are synchronous to clk_sys.
`timescale 1ns/10ps
module sticky_status (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic clkEn,
   input wire logic [5:0] setEvents,
   input wire logic [5:0] clearMask,
   output logic [5:0] flags
);
   typedef struct packed {
      logic [5:0] flags;
   } state_s;
   state_s st;
   state_s next_st;
   always_comb begin
      next_st = st;
      // Set wins over a clear arriving in the same cycle
      for (int i = 0; i < 6; i++) begin
         next_st.flags[i] = setEvents[i] | (st.flags[i] & ~clearMask[i]);
      end
   end
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st <= '0;
      end else if (clkEn) begin
         st <= next_st;
      end
   end
   assign flags = st.flags;
endmodule : sticky_status

//--- design/pci_controller_register_map.sv
// PCI controller register bank: configuration header, general control, FIFO interface.
// Assumes one internal register port (processor or external master via internal bus)
// and one configuration port fed by the PCI target logic.
`timescale 1ns/10ps
`include "pci_regs_map.svh"
module pci_controller_register_map #(
   parameter logic [15:0] DEVICE_CODE = `IDENT_DEVICE,  // Arbitrary value
   parameter logic [15:0] VENDOR_CODE = `IDENT_VENDOR   // Arbitrary value
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic clkEn,
   input wire pci_regs_pkg::reg_req_s regReq,
   output pci_regs_pkg::reg_rsp_s regRsp,
   input wire pci_regs_pkg::cfg_req_s cfgReq,
   output pci_regs_pkg::reg_rsp_s cfgRsp,
   input wire pci_regs_pkg::err_events_s errEvents,
   input wire logic [31:0] txStatusIn,
   input wire logic [31:0] rxStatusIn,
   input wire logic [31:0] txNextAddrIn,
   input wire logic [31:0] txLastWordIn,
   input wire logic [31:0] txDoneIn,
   input wire logic [31:0] rxNextAddrIn,
   input wire logic [31:0] rxDoneIn,
   output logic pci_bus_reset_out_n,
   output logic [31:0] statusCommand,
   output logic [31:0] globalControl
);
   import pci_regs_pkg::*;

   localparam int NUM_RW = 34;

   typedef struct packed {
      bus_state_e regState;
      reg_rsp_s regRsp;
      reg_rsp_s cfgRsp;
      logic resetOutN;
      logic [9:0] cmdBits;
      logic [31:0] cfg1;
      logic [31:0] gscr;
      logic [NUM_RW-1:0][31:0] rw;
      logic [31:0] txSticky;
      logic [31:0] rxSticky;
      logic [31:0] txFifoSticky;
      logic [31:0] rxFifoSticky;
   } state_s;

   state_s st;
   state_s next_st;
   logic [5:0] errFlags;
   logic [5:0] errClear;

   // Plain read/write registers held in one indexed array
   function automatic int rwIndex(input logic [15:0] a);
      unique case (a)
         `OFF_BAR0: return 0;
         `OFF_BAR1: return 1;
         `OFF_CISPTR: return 2;
         `OFF_SUBSYS: return 3;
         `OFF_ROMBASE: return 4;
         `OFF_CAPPTR: return 5;
         `OFF_CFG2: return 6;
         `OFF_TBAT0: return 7;
         `OFF_TBAT1: return 8;
         `OFF_TCTL: return 9;
         `OFF_IW0: return 10;
         `OFF_IW1: return 11;
         `OFF_IW2: return 12;
         `OFF_IWCFG: return 13;
         `OFF_ICTL: return 14;
         `OFF_ISTAT: return 15;
         `OFF_TX_SIZE: return 16;
         `OFF_TX_START: return 17;
         `OFF_TX_XFER: return 18;
         `OFF_TX_ENABLE: return 19;
         `OFF_TX_FDATA: return 20;
         `OFF_TX_FCTL: return 21;
         `OFF_TX_FALARM: return 22;
         `OFF_TX_FRDPTR: return 23;
         `OFF_TX_FWRPTR: return 24;
         `OFF_RX_SIZE: return 25;
         `OFF_RX_START: return 26;
         `OFF_RX_XFER: return 27;
         `OFF_RX_ENABLE: return 28;
         `OFF_RX_FDATA: return 29;
         `OFF_RX_FCTL: return 30;
         `OFF_RX_FALARM: return 31;
         `OFF_RX_FRDPTR: return 32;
         `OFF_RX_FWRPTR: return 33;
         default: return -1;
      endcase
   endfunction : rwIndex

   // Both module offset windows; anything outside them is unmapped
   function automatic logic inRange(input logic [15:0] a);
      return ((a >= `CFG_BASE) && (a <= `CFG_LAST)) || ((a >= `FIFO_BASE) && (a <= `FIFO_LAST));
   endfunction : inRange

   function automatic logic [31:0] scValue(input logic [5:0] f, input logic [9:0] c);
      logic [31:0] v;
      v = `SC_FIXED;
      v[`SC_PE_POS] = f[5];
      v[`SC_SE_POS] = f[4];
      v[`SC_MA_POS] = f[3];
      v[`SC_TR_POS] = f[2];
      v[`SC_TS_POS] = f[1];
      v[`SC_DP_POS] = f[0];
      v[9:0] = c & 10'(`SC_RW_MASK);
      return v;
   endfunction : scValue

   // Shared read decode for both ports; unknown offsets give zero
   function automatic logic [31:0] readReg(input logic [15:0] a, input state_s s, input logic [5:0] f,
                                           input logic [31:0] txS, input logic [31:0] rxS,
                                           input logic [31:0] tna, input logic [31:0] tlw,
                                           input logic [31:0] tdc, input logic [31:0] rna,
                                           input logic [31:0] rdc);
      int idx;
      idx = rwIndex(a);
      if (!inRange(a) || a[1:0] != 2'b00) begin
         return 32'h0000_0000;
      end
      if (idx >= 0) begin
         return s.rw[idx];
      end
      unique case (a)
         `OFF_IDENT: return {DEVICE_CODE, VENDOR_CODE};
         `OFF_STATCMD: return scValue(f, s.cmdBits);
         `OFF_CLASSREV: return `CLASSREV_VALUE;
         `OFF_CFG1: return s.cfg1;
         `OFF_GSCR: return s.gscr;
         `OFF_TX_NEXT: return tna;
         `OFF_TX_LASTWORD: return tlw;
         `OFF_TX_DONE: return tdc;
         `OFF_TX_STATUS: return s.txSticky | txS;
         `OFF_TX_FSTAT: return s.txFifoSticky;
         `OFF_RX_NEXT: return rna;
         `OFF_RX_DONE: return rdc;
         `OFF_RX_STATUS: return s.rxSticky | rxS;
         `OFF_RX_FSTAT: return s.rxFifoSticky;
         default: return 32'h0000_0000;
      endcase
   endfunction : readReg

   sticky_status errStatus (
      .clk_sys(clk_sys),
      .srst(srst),
      .clkEn(clkEn),
      .setEvents({errEvents.parityErr, errEvents.sysErrSignalled, errEvents.masterAbort,
                  errEvents.targetAbortRcvd, errEvents.targetAbortSent, errEvents.masterDataParity}),
      .clearMask(errClear),
      .flags(errFlags)
   );

   logic [15:0] cfgAddr;
   logic cfgRsvd;
   logic cfgWrStat;
   assign cfgAddr = 16'(`CFG_BASE + {8'h00, cfgReq.dword, 2'b00});
   assign cfgRsvd = ({2'b00, cfgReq.dword} >= `CFG_RSVD_LO) && ({2'b00, cfgReq.dword} <= `CFG_RSVD_HI);
   assign cfgWrStat = cfgReq.req && cfgReq.write && (cfgAddr == `OFF_STATCMD);
   // Only configuration writes clear sticky errors; internal writes leave them
   assign errClear = cfgWrStat ? {cfgReq.wdata[`SC_PE_POS], cfgReq.wdata[`SC_SE_POS],
                                  cfgReq.wdata[`SC_MA_POS], cfgReq.wdata[`SC_TR_POS],
                                  cfgReq.wdata[`SC_TS_POS], cfgReq.wdata[`SC_DP_POS]} : 6'h00;

   always_comb begin
      int wi;
      wi = -1;
      next_st = st;
      next_st.regRsp.ack = 1'b0;
      next_st.cfgRsp.ack = 1'b0;
      // Internal port: processor or external master bridged onto the internal bus; no hold-bit gate
      unique case (st.regState)
         ST_IDLE: begin
            if (regReq.req) begin
               next_st.regState = ST_ANSWER;
               next_st.regRsp.ack = 1'b1;
               next_st.regRsp.rdata = regReq.write ? 32'h0000_0000 :
                  readReg(regReq.addr, st, errFlags, txStatusIn, rxStatusIn, txNextAddrIn,
                          txLastWordIn, txDoneIn, rxNextAddrIn, rxDoneIn);
               if (regReq.write && inRange(regReq.addr) && regReq.addr[1:0] == 2'b00) begin
                  wi = rwIndex(regReq.addr);
                  if (wi >= 0) begin
                     next_st.rw[wi] = regReq.wdata;
                  end
                  unique case (regReq.addr)
                     `OFF_STATCMD: next_st.cmdBits = regReq.wdata[9:0] & 10'(`SC_RW_MASK);
                     `OFF_CFG1: next_st.cfg1 = regReq.wdata & `CFG1_RW_MASK;
                     `OFF_GSCR: next_st.gscr = regReq.wdata;
                     `OFF_TX_STATUS: next_st.txSticky = st.txSticky & ~regReq.wdata;
                     `OFF_RX_STATUS: next_st.rxSticky = st.rxSticky & ~regReq.wdata;
                     `OFF_TX_FSTAT: next_st.txFifoSticky = st.txFifoSticky & ~regReq.wdata;
                     `OFF_RX_FSTAT: next_st.rxFifoSticky = st.rxFifoSticky & ~regReq.wdata;
                     default: ; // Read-only or unmapped: ignored
                  endcase
               end
            end
         end
         ST_ANSWER: begin
            // One idle cycle between requests keeps the handshake unambiguous
            next_st.regState = ST_IDLE;
         end
      endcase
      // Configuration port: header dwords, reserved dwords read zero
      if (cfgReq.req) begin
         next_st.cfgRsp.ack = 1'b1;
         next_st.cfgRsp.rdata = (cfgReq.write || cfgRsvd) ? 32'h0000_0000 :
            readReg(cfgAddr, st, errFlags, txStatusIn, rxStatusIn, txNextAddrIn,
                    txLastWordIn, txDoneIn, rxNextAddrIn, rxDoneIn);
         if (cfgReq.write && !cfgRsvd) begin
            wi = rwIndex(cfgAddr);
            if (wi >= 0 && wi <= 6) begin
               next_st.rw[wi] = cfgReq.wdata;
            end
            if (cfgAddr == `OFF_STATCMD) begin
               next_st.cmdBits = cfgReq.wdata[9:0] & 10'(`SC_RW_MASK);
            end
            if (cfgAddr == `OFF_CFG1) begin
               next_st.cfg1 = cfgReq.wdata & `CFG1_RW_MASK;
            end
         end
      end
      // Hardware-set status sticks; set wins over a clearing write
      next_st.txSticky = next_st.txSticky | txStatusIn;
      next_st.rxSticky = next_st.rxSticky | rxStatusIn;
      next_st.resetOutN = ~next_st.gscr[`GSCR_RESET_HOLD_POS];
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st <= '0;
         st.regState <= ST_IDLE;
         st.gscr <= `GSCR_RESET;
         st.resetOutN <= 1'b0;
      end else if (clkEn) begin
         st <= next_st;
      end
   end

   assign regRsp = st.regRsp;
   assign cfgRsp = st.cfgRsp;
   assign pci_bus_reset_out_n = st.resetOutN;
   assign globalControl = st.gscr;
   // Sticky bits come from the child's flops, command bits from this module's, the rest from SC_FIXED
   assign statusCommand = scValue(errFlags, st.cmdBits);
endmodule : pci_controller_register_map

//--- sim/pci_map_assertions.sv
// Port checker for the PCI register bank.
// Assumes binding to pci_controller_register_map.
`timescale 1ns/10ps
`include "pci_regs_map.svh"
module pci_map_assertions #(
   parameter logic [15:0] DEVICE_CODE = 16'h0,
   parameter logic [15:0] VENDOR_CODE = 16'h0
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic clkEn,
   input wire pci_regs_pkg::reg_req_s regReq,
   input wire pci_regs_pkg::reg_rsp_s regRsp,
   input wire pci_regs_pkg::cfg_req_s cfgReq,
   input wire pci_regs_pkg::reg_rsp_s cfgRsp,
   input wire pci_regs_pkg::err_events_s errEvents,
   input wire logic pci_bus_reset_out_n,
   input wire logic [31:0] statusCommand,
   input wire logic [31:0] globalControl
);
   import pci_regs_pkg::*;
   reg_req_s pr;
   cfg_req_s pc;
   logic [31:0] ps;
   // Requests are kept one cycle so each answer meets its cause
   always_ff @(posedge clk_sys) begin
      pr <= regReq;
      pc <= cfgReq;
      ps <= statusCommand;
   end
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (srst);
   a_hold_out: assert property ($stable(globalControl[0])
      |-> pci_bus_reset_out_n == !globalControl[0]) else $error("reset out vs hold bit");
   a_reset_state: assert property ($past(srst) |-> !pci_bus_reset_out_n
      && globalControl == `GSCR_RESET && statusCommand == `SC_FIXED) else $error("state after reset");
   a_ack_single: assert property (regRsp.ack |-> pr.req ##1 !regRsp.ack)
      else $error("register ack");
   a_cfg_answer: assert property (cfgReq.req && clkEn |=> cfgRsp.ack)
      else $error("config ack");
   a_ident_fixed: assert property (regRsp.ack && !pr.write && pr.addr == `OFF_IDENT
      |-> regRsp.rdata == {DEVICE_CODE, VENDOR_CODE}) else $error("identity value");
   a_unaligned_zero: assert property (regRsp.ack && pr.addr[1:0] != 2'h0
      |-> regRsp.rdata == 32'h0) else $error("unaligned read");
   a_rsvd_cfg_zero: assert property (cfgRsp.ack && pc.dword >= `CFG_RSVD_LO
      |-> cfgRsp.rdata == 32'h0) else $error("reserved dword read");
   a_sticky_clear: assert property (!$past(srst) && |(ps & ~statusCommand & `SC_STICKY_MASK)
      |-> pc.req && pc.write && pc.dword == 6'h1) else $error("sticky cleared without config write");
   a_sticky_set: assert property (errEvents.parityErr && clkEn |-> ##[1:2] statusCommand[31])
      else $error("parity sticky not set");
   a_fixed_bits: assert property ((statusCommand & ~(`SC_STICKY_MASK | `SC_RW_MASK)) == `SC_FIXED)
      else $error("fixed status bits");
endmodule : pci_map_assertions

//--- sim/pci_cfg_master.sv
// Model of the external PCI master issuing configuration cycles.
// Assumes the bank answers one cycle after each taken request.
`timescale 1ns/10ps
module pci_cfg_master (
   input wire logic clk_sys,
   input wire logic busRstN,
   input wire pci_regs_pkg::reg_rsp_s cfgRsp,
   output pci_regs_pkg::cfg_req_s cfgReq
);
   import pci_regs_pkg::*;
   initial cfgReq = '0;
   task automatic cfgCycle(input logic wr, input logic [5:0] dw, input logic [31:0] wd,
         output logic [31:0] rd, output logic ok);
      int n = 0;
      // Stays off the bus for up to 1000 cycles while devices are held in reset
      while (busRstN !== 1'b1 && n < 1000) begin
         @(negedge clk_sys);
         n++;
      end
      @(negedge clk_sys);
      cfgReq = '{1'b1, wr, dw, wd};
      @(negedge clk_sys);
      ok = cfgRsp.ack;
      rd = cfgRsp.rdata;
      cfgReq.req = 1'b0;
      cfgReq.wdata = ~wd;
   endtask : cfgCycle
endmodule : pci_cfg_master

//--- sim/pci_controller_register_map_bench.sv
// Self-checking bench for the PCI controller register bank.
// Assumes pci_cfg_master on the config port and the port checker bound below.
`timescale 1ns/10ps
`include "pci_regs_map.svh"
module pci_controller_register_map_bench;
   import pci_regs_pkg::*;
   localparam logic [15:0] DEV = 16'h00a5; // Arbitrary value
   localparam logic [15:0] VEN = 16'h005a; // Arbitrary value
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   reg_req_s regReq = '0;
   reg_rsp_s regRsp;
   reg_rsp_s cfgRsp;
   cfg_req_s cfgReq;
   err_events_s e = '0;
   logic [31:0] lvl [5] = '{default: 32'h0};
   logic [31:0] txs = 32'h0;
   logic [31:0] rxs = 32'h0;
   logic [15:0] rwA [8] = '{16'h8400, 16'h8404, 16'h8408, 16'h840c, 16'h8480, 16'h8484, 16'h84c8, 16'h84d4};
   logic [15:0] noA [8] = '{16'h0b18, 16'h0b38, 16'h0b40, 16'h0b7c, 16'h8420, 16'h8494, 16'h84d8, 16'h8401};
   logic [15:0] roA [5] = '{16'h8410, 16'h8414, 16'h8418, 16'h8490, 16'h8498};
   logic busRstN;
   logic ok;
   logic [31:0] sc, gc, rd, v;
   int fails = 0;
   int checks = 0;
   int cyc = 0;
   always #2.5 clk_sys = ~clk_sys;
   pci_controller_register_map #(.DEVICE_CODE(DEV), .VENDOR_CODE(VEN)) DUT (.clk_sys(clk_sys), .srst(srst),
      .clkEn(1'b1), .regReq(regReq), .regRsp(regRsp), .cfgReq(cfgReq), .cfgRsp(cfgRsp), .errEvents(e),
      .txStatusIn(txs), .rxStatusIn(rxs), .txNextAddrIn(lvl[0]), .txLastWordIn(lvl[1]),
      .txDoneIn(lvl[2]), .rxNextAddrIn(lvl[3]), .rxDoneIn(lvl[4]), .pci_bus_reset_out_n(busRstN),
      .statusCommand(sc), .globalControl(gc));
   pci_cfg_master host (.clk_sys(clk_sys), .busRstN(busRstN), .cfgRsp(cfgRsp), .cfgReq(cfgReq));
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask : check
   task automatic acc(input logic wr, input logic [15:0] a, input logic [31:0] wd);
      @(negedge clk_sys);
      regReq = '{1'b1, wr, a, wd};
      @(negedge clk_sys);
      regReq.req = 1'b0;
      regReq.wdata = ~wd;
      check("ack", 32'h1, {31'h0, regRsp.ack});
      rd = regRsp.rdata;
   endtask : acc
   task automatic cfg(input logic wr, input logic [5:0] dw, input logic [31:0] wd);
      host.cfgCycle(wr, dw, wd, rd, ok);
      check("cfg ack", 32'h1, {31'h0, ok});
   endtask : cfg
   // Sticky error bits as the status word shows them
   function automatic logic [31:0] stk(input err_events_s x);
      return {x[5:1], 2'b00, x[0], 24'h0};
   endfunction : stk
   task automatic close_out;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : close_out
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         close_out();
      end
   end
   initial begin
      v = $urandom(96080);
      repeat (20) @(negedge clk_sys);
      srst = 1'b0;
      check("reset out", 32'h0, {31'h0, busRstN});
      check("gscr", `GSCR_RESET, gc);
      acc(1'b1, `OFF_IDENT, $urandom);
      acc(1'b0, `OFF_IDENT, 32'h0);
      check("ident", {DEV, VEN}, rd);
      $display("reset test done");
      // First pass with the hold bit set, second with it clear
      repeat (2) begin
         foreach (rwA[i]) begin
            v = $urandom;
            acc(1'b1, rwA[i], v);
            acc(1'b0, rwA[i], 32'h0);
            check("rw reg", v, rd);
         end
         acc(1'b1, `OFF_GSCR, 32'h0);
         check("reset out", 32'h1, {31'h0, busRstN});
      end
      foreach (noA[i]) begin
         acc(1'b1, noA[i], 32'hffff_ffff);
         acc(1'b0, noA[i], 32'h0);
         check("unmapped", 32'h0, rd);
      end
      foreach (lvl[i]) lvl[i] = $urandom;
      foreach (roA[i]) begin
         acc(1'b1, roA[i], ~lvl[i]);
         acc(1'b0, roA[i], 32'h0);
         check("read only", lvl[i], rd);
      end
      v = $urandom;
      txs = v;
      rxs = ~v;
      @(negedge clk_sys);
      txs = 32'h0;
      rxs = 32'h0;
      acc(1'b0, `OFF_TX_STATUS, 32'h0);
      check("tx status", v, rd);
      acc(1'b0, `OFF_RX_STATUS, 32'h0);
      check("rx status", ~v, rd);
      acc(1'b1, `OFF_TX_STATUS, v);
      acc(1'b0, `OFF_TX_STATUS, 32'h0);
      check("tx status cleared", 32'h0, rd);
      $display("map test done");
      cfg(1'b0, 6'h0, 32'h0);
      check("cfg ident", {DEV, VEN}, rd);
      v = $urandom;
      cfg(1'b1, 6'h3, v);
      acc(1'b0, `OFF_CFG1, 32'h0);
      check("config one", v & `CFG1_RW_MASK, rd);
      cfg(1'b1, v[5:0] | 6'h10, v);
      cfg(1'b0, v[5:0] | 6'h10, 32'h0);
      check("reserved dword", 32'h0, rd);
      $display("config test done");
      cfg(1'b1, 6'h1, 32'h40);
      @(negedge clk_sys);
      v = {26'h0, 6'h20 | 6'($urandom)};
      e = err_events_s'(v[5:0]);
      @(negedge clk_sys);
      e = '0;
      @(negedge clk_sys);
      check("sticky set", stk(err_events_s'(v[5:0])) | `SC_FIXED | 32'h40, sc);
      acc(1'b1, `OFF_STATCMD, 32'hffff_ffff);
      cfg(1'b1, 6'h1, 32'h0);
      check("sticky kept", stk(err_events_s'(v[5:0])) | `SC_FIXED, sc);
      cfg(1'b1, 6'h1, stk(err_events_s'(v[5:0])));
      check("sticky cleared", `SC_FIXED, sc);
      $display("sticky test done");
      close_out();
   end
endmodule : pci_controller_register_map_bench
bind pci_controller_register_map pci_map_assertions #(.DEVICE_CODE(DEVICE_CODE), .VENDOR_CODE(VENDOR_CODE))
   chk (.clk_sys(clk_sys), .srst(srst), .clkEn(clkEn), .regReq(regReq), .regRsp(regRsp), .cfgReq(cfgReq),
   .cfgRsp(cfgRsp), .errEvents(errEvents), .pci_bus_reset_out_n(pci_bus_reset_out_n),
   .statusCommand(statusCommand), .globalControl(globalControl));
